// ---- sram_port_pkg.sv ----
// Constants, widths and state type for the pipelined burst SRAM port.
// Assumes one 20 MHz clock; all timing is counted in cycles of it.
//
// Notes on behaviour
// - A burst steps only address bits 1:0 through four words; upper bits held.
// - Advance high holds the burst address; a write in that cycle rewrites the same word with new data.
// - Either strobe latches the external address when selected; a processor strobe start is always a read, a controller strobe start a write if lanes are enabled.
// - Byte-write enable with every lane selected writes all lanes, as global write does.
// - Input registers are not kept over power-down; a fresh address follows waking.
// - After the fourth burst word the counter wraps to the burst start.
// - Order select high gives interleaved (start xor count), low gives linear order.
// - Any mix of lanes is written: lanes whose select is low under byte-write enable.

package sram_port_pkg;

  localparam int ADDR_W        = 18;
  localparam int LANES         = 4;
  localparam int LANE_W        = 9;
  localparam int DATA_W        = LANES * LANE_W;
  localparam int MEM_AW        = 4;
  localparam int MEM_DEPTH     = 1 << MEM_AW;
  localparam int FIFO_DEPTH    = 8;
  localparam int FIFO_W        = MEM_AW + DATA_W + LANES;

  localparam logic [1:0]       BURST_CNT_RST  = 2'h0;
  localparam logic [LANES-1:0] LANES_ALL      = 4'hF;
  localparam logic [LANES-1:0] LANES_NONE     = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RST      = 36'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST      = 18'h0;

  // Timing in ns and derived cycle counts (least times round up)
  localparam int CLK_PERIOD_NS    = 50;
  localparam int SLEEP_RECOVER_NS = 100;
  localparam int SLEEP_MIN_NS     = 100;
  localparam int CFG_SETUP_NS     = 30;
  localparam int SLEEP_RECOVER_CYC_I =
    (SLEEP_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CFG_SETUP_CYC_I =
    (CFG_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SLEEP_RECOVER_CYC = 4'(SLEEP_RECOVER_CYC_I);
  localparam logic [3:0] CFG_SETUP_CYC     = 4'(CFG_SETUP_CYC_I);
  localparam logic [3:0] WAKE_CNT_RST      = 4'h0;

  typedef enum {ST_IDLE, ST_BURST, ST_SLEEP, ST_WAKE} state_type;

endpackage : sram_port_pkg

// ---- sram_write_fifo.sv ----
// Write queue between the port and the storage array.
// Assumes one clock; the drain side may stall, which fills the queue.
`timescale 1ns/1ps

module sram_write_fifo #(
  parameter int WIDTH = 44,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] slot_ff [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [PTR_W:0]   count_ff;
  logic [PTR_W:0]   nxt_count;
  logic             in_ready_ff;
  logic             push;
  logic             pop;

  assign out_valid = (count_ff != '0);
  assign out_data  = slot_ff[rd_ptr_ff];
  assign in_ready  = in_ready_ff;
  assign push      = in_valid & in_ready_ff;
  assign pop       = out_valid & out_ready;

  always_comb
  begin
    nxt_count = count_ff;
    if (push && !pop)
    begin
      nxt_count = count_ff + 1'b1;
    end
    else if (pop && !push)
    begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      count_ff    <= '0;
      in_ready_ff <= 1'b1;
    end
    else
    begin
      count_ff    <= nxt_count;
      in_ready_ff <= (nxt_count != (PTR_W+1)'(DEPTH));
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_ff <= (wr_ptr_ff == (PTR_W)'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_ff <= (rd_ptr_ff == (PTR_W)'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      slot_ff[wr_ptr_ff] <= in_data;
    end
  end

endmodule : sram_write_fifo

// ---- sram_burst_port.sv ----
// Synchronous port of a pipelined burst SRAM with flip-flop storage.
// Assumes all inputs synchronous to CLK; data pins split into in/out/enable.
`timescale 1ns/1ps

module sram_burst_port (
  input  wire logic                               CLK,
  input  wire logic                               RESET,
  input  wire logic [sram_port_pkg::ADDR_W-1:0]   ADDR,
  input  wire logic                               CHIP_EN_N,
  input  wire logic                               SELECT_HI,
  input  wire logic                               SELECT_LO_N,
  input  wire logic                               PROC_ADDR_STROBE_N,
  input  wire logic                               CTRL_ADDR_STROBE_N,
  input  wire logic                               BURST_ADVANCE_N,
  input  wire logic                               GLOBAL_WRITE_N,
  input  wire logic                               BYTE_WRITE_EN_N,
  input  wire logic [sram_port_pkg::LANES-1:0]    BYTE_LANE_SEL_N,
  input  wire logic                               BURST_ORDER_SEL_N,
  input  wire logic                               SLEEP_REQ,
  input  wire logic [sram_port_pkg::DATA_W-1:0]   DQ_I,
  output logic      [sram_port_pkg::DATA_W-1:0]   DQ_O,
  output logic                                    DQ_OE,
  output logic                                    WRITE_READY,
  output logic                                    SLEEPING
);

  sram_port_pkg::state_type            state_ff;
  sram_port_pkg::state_type            nxt_state;
  logic [sram_port_pkg::ADDR_W-1:0]    base_ff;
  logic [sram_port_pkg::ADDR_W-1:0]    nxt_base;
  logic [1:0]                          cnt_ff;
  logic [1:0]                          nxt_cnt;
  logic [3:0]                          wake_cnt_ff;
  logic [sram_port_pkg::DATA_W-1:0]    dq_o_ff;
  logic                                dq_oe_ff;
  logic                                sleeping_ff;

  logic                                selected;
  logic                                proc_start;
  logic                                ctrl_start;
  logic [sram_port_pkg::LANES-1:0]     lane_wr;
  logic                                access;
  logic                                is_write;
  logic [sram_port_pkg::ADDR_W-1:0]    eff_addr;
  logic [sram_port_pkg::MEM_AW-1:0]    eff_idx;
  logic [sram_port_pkg::DATA_W-1:0]    rd_word;

  logic                                fifo_in_ready;
  logic                                fifo_out_valid;
  logic                                drain_ready;
  logic [sram_port_pkg::FIFO_W-1:0]    fifo_in_data;
  logic [sram_port_pkg::FIFO_W-1:0]    fifo_out_data;
  logic [sram_port_pkg::MEM_AW-1:0]    drain_idx;
  logic [sram_port_pkg::DATA_W-1:0]    drain_data;
  logic [sram_port_pkg::LANES-1:0]     drain_lanes;

  // Low two address bits for burst step
  function automatic logic [1:0] burst_low(input logic [1:0] start,
                                           input logic [1:0] step,
                                           input logic       interleave);
    logic [1:0] res;
    if (interleave)
    begin
      res = start ^ step;
    end
    else
    begin
      res = start + step;
    end
    return res;
  endfunction : burst_low

  assign selected   = !CHIP_EN_N && SELECT_HI && !SELECT_LO_N;
  // Processor strobe is ignored while chip enable is high
  assign proc_start = !PROC_ADDR_STROBE_N && !CHIP_EN_N;
  assign ctrl_start = !CTRL_ADDR_STROBE_N && !proc_start;

  // Write lanes: global write, or byte enable with per-lane selects
  always_comb
  begin
    if (!GLOBAL_WRITE_N)
    begin
      lane_wr = sram_port_pkg::LANES_ALL;
    end
    else if (!BYTE_WRITE_EN_N)
    begin
      lane_wr = ~BYTE_LANE_SEL_N;
    end
    else
    begin
      lane_wr = sram_port_pkg::LANES_NONE;
    end
  end

  // Cycle decode: start, deselect, continue or suspend
  always_comb
  begin
    nxt_state = state_ff;
    nxt_base  = base_ff;
    nxt_cnt   = cnt_ff;
    access    = 1'b0;
    is_write  = 1'b0;
    eff_addr  = base_ff;
    case (state_ff)
      sram_port_pkg::ST_SLEEP:
      begin
        if (!SLEEP_REQ)
        begin
          nxt_state = sram_port_pkg::ST_WAKE;
        end
      end
      sram_port_pkg::ST_WAKE:
      begin
        if (SLEEP_REQ)
        begin
          nxt_state = sram_port_pkg::ST_SLEEP;
        end
        else if (wake_cnt_ff >= sram_port_pkg::SLEEP_RECOVER_CYC)
        begin
          nxt_state = sram_port_pkg::ST_IDLE;
        end
      end
      sram_port_pkg::ST_IDLE,
      sram_port_pkg::ST_BURST:
      begin
        if (SLEEP_REQ)
        begin
          nxt_state = sram_port_pkg::ST_SLEEP;
        end
        else if ((proc_start || ctrl_start) && selected)
        begin
          nxt_state = sram_port_pkg::ST_BURST;
          nxt_base  = ADDR;
          nxt_cnt   = sram_port_pkg::BURST_CNT_RST;
          access    = 1'b1;
          eff_addr  = ADDR;
          is_write  = ctrl_start && (lane_wr != sram_port_pkg::LANES_NONE);
        end
        else if (proc_start || ctrl_start)
        begin
          nxt_state = sram_port_pkg::ST_IDLE;
        end
        else if (state_ff == sram_port_pkg::ST_BURST)
        begin
          if (!BURST_ADVANCE_N)
          begin
            nxt_cnt = cnt_ff + 1'b1;
          end
          access   = 1'b1;
          eff_addr = {base_ff[sram_port_pkg::ADDR_W-1:2],
                      burst_low(base_ff[1:0], nxt_cnt, BURST_ORDER_SEL_N)};
          is_write = (lane_wr != sram_port_pkg::LANES_NONE);
        end
      end
      default:
      begin
        nxt_state = sram_port_pkg::ST_IDLE;
      end
    endcase
  end

  assign eff_idx = eff_addr[sram_port_pkg::MEM_AW-1:0];

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      state_ff <= sram_port_pkg::ST_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Burst registers are cleared by sleep and are not kept across it
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      base_ff <= sram_port_pkg::ADDR_RST;
      cnt_ff  <= sram_port_pkg::BURST_CNT_RST;
    end
    else if (nxt_state == sram_port_pkg::ST_SLEEP)
    begin
      base_ff <= sram_port_pkg::ADDR_RST;
      cnt_ff  <= sram_port_pkg::BURST_CNT_RST;
    end
    else
    begin
      base_ff <= nxt_base;
      cnt_ff  <= nxt_cnt;
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      wake_cnt_ff <= sram_port_pkg::WAKE_CNT_RST;
      sleeping_ff <= 1'b0;
    end
    else
    begin
      sleeping_ff <= (nxt_state == sram_port_pkg::ST_SLEEP) ||
                     (nxt_state == sram_port_pkg::ST_WAKE);
      if (state_ff == sram_port_pkg::ST_WAKE)
      begin
        wake_cnt_ff <= wake_cnt_ff + 1'b1;
      end
      else
      begin
        wake_cnt_ff <= sram_port_pkg::WAKE_CNT_RST;
      end
    end
  end

  // Pipelined read: word on DQ from the edge that registers the address
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      dq_o_ff  <= sram_port_pkg::DATA_RST;
      dq_oe_ff <= 1'b0;
    end
    else
    begin
      dq_oe_ff <= access && !is_write;
      if (access && !is_write)
      begin
        dq_o_ff <= rd_word;
      end
    end
  end

  assign fifo_in_data = {eff_idx, DQ_I, lane_wr};
  assign drain_idx    = fifo_out_data[sram_port_pkg::FIFO_W-1 -: sram_port_pkg::MEM_AW];
  assign drain_data   = fifo_out_data[sram_port_pkg::LANES +: sram_port_pkg::DATA_W];
  assign drain_lanes  = fifo_out_data[sram_port_pkg::LANES-1:0];
  // Array has one port; a read in this cycle stalls the drain
  assign drain_ready  = !(access && !is_write);

  sram_write_fifo #(
    .WIDTH (sram_port_pkg::FIFO_W),
    .DEPTH (sram_port_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (CLK),
    .reset     (RESET),
    .in_valid  (access && is_write),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (drain_ready),
    .out_data  (fifo_out_data)
  );

  genvar lane;
  generate
    for (lane = 0; lane < sram_port_pkg::LANES; lane++)
    begin : g_lane
      logic [sram_port_pkg::LANE_W-1:0] lane_mem_ff [sram_port_pkg::MEM_DEPTH];

      assign rd_word[lane*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W] =
        lane_mem_ff[eff_idx];

      always_ff @(posedge CLK)
      begin
        if (fifo_out_valid && drain_ready && drain_lanes[lane])
        begin
          lane_mem_ff[drain_idx] <=
            drain_data[lane*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W];
        end
      end
    end
  endgenerate

  assign DQ_O        = dq_o_ff;
  assign DQ_OE       = dq_oe_ff;
  assign WRITE_READY = fifo_in_ready;
  assign SLEEPING    = sleeping_ff;

endmodule : sram_burst_port

// ---- sram_port_checker.sv ----
// Checker for the burst SRAM port: read start, write start, select, suspend, sleep.
// Assumes it is bound to sram_burst_port and sees only that module's ports.
`timescale 1ns/1ps

module sram_port_checker (
  input wire logic                             CLK,
  input wire logic                             RESET,
  input wire logic [sram_port_pkg::ADDR_W-1:0] ADDR,
  input wire logic                             CHIP_EN_N,
  input wire logic                             SELECT_HI,
  input wire logic                             SELECT_LO_N,
  input wire logic                             PROC_ADDR_STROBE_N,
  input wire logic                             CTRL_ADDR_STROBE_N,
  input wire logic                             BURST_ADVANCE_N,
  input wire logic                             GLOBAL_WRITE_N,
  input wire logic                             BYTE_WRITE_EN_N,
  input wire logic [sram_port_pkg::LANES-1:0]  BYTE_LANE_SEL_N,
  input wire logic                             BURST_ORDER_SEL_N,
  input wire logic                             SLEEP_REQ,
  input wire logic [sram_port_pkg::DATA_W-1:0] DQ_I,
  input wire logic [sram_port_pkg::DATA_W-1:0] DQ_O,
  input wire logic                             DQ_OE,
  input wire logic                             WRITE_READY,
  input wire logic                             SLEEPING
);
  logic sel;
  logic ok;
  assign sel = !CHIP_EN_N && SELECT_HI && !SELECT_LO_N;
  assign ok  = !SLEEPING && !SLEEP_REQ;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  property p_rd_oe;
    sel && !CTRL_ADDR_STROBE_N && GLOBAL_WRITE_N && (BYTE_WRITE_EN_N || &BYTE_LANE_SEL_N)
      && ok |=> DQ_OE;
  endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("read start without output");
  property p_proc_rd;
    sel && !PROC_ADDR_STROBE_N && ok |=> DQ_OE;
  endproperty
  a_proc_rd: assert property (p_proc_rd) else $error("processor start not a read");
  property p_wr;
    sel && !CTRL_ADDR_STROBE_N && PROC_ADDR_STROBE_N && ok
      && (!GLOBAL_WRITE_N || (!BYTE_WRITE_EN_N && !(|BYTE_LANE_SEL_N))) |=> !DQ_OE;
  endproperty
  a_wr: assert property (p_wr) else $error("write start drove data out");
  property p_desel;
    !CTRL_ADDR_STROBE_N && !sel && ok |=> !DQ_OE;
  endproperty
  a_desel: assert property (p_desel) else $error("deselect cycle drove data out");
  property p_suspend;
    DQ_OE && BURST_ADVANCE_N && PROC_ADDR_STROBE_N && CTRL_ADDR_STROBE_N && GLOBAL_WRITE_N
      && BYTE_WRITE_EN_N && ok |=> DQ_OE && $stable(DQ_O);
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspended burst moved");
  property p_dq_hold;
    !DQ_OE |-> $stable(DQ_O);
  endproperty
  a_dq_hold: assert property (p_dq_hold) else $error("read data changed without read");
  property p_sleep_in;
    SLEEP_REQ |=> SLEEPING && !DQ_OE;
  endproperty
  a_sleep_in: assert property (p_sleep_in) else $error("sleep not entered");
  property p_sleep_out;
    $fell(SLEEP_REQ) |-> SLEEPING [*2] ##[1:4] !SLEEPING;
  endproperty
  a_sleep_out: assert property (p_sleep_out) else $error("wake recovery wrong");
endmodule : sram_port_checker

bind sram_burst_port sram_port_checker i_chk (
  .CLK                (CLK),
  .RESET              (RESET),
  .ADDR               (ADDR),
  .CHIP_EN_N          (CHIP_EN_N),
  .SELECT_HI          (SELECT_HI),
  .SELECT_LO_N        (SELECT_LO_N),
  .PROC_ADDR_STROBE_N (PROC_ADDR_STROBE_N),
  .CTRL_ADDR_STROBE_N (CTRL_ADDR_STROBE_N),
  .BURST_ADVANCE_N    (BURST_ADVANCE_N),
  .GLOBAL_WRITE_N     (GLOBAL_WRITE_N),
  .BYTE_WRITE_EN_N    (BYTE_WRITE_EN_N),
  .BYTE_LANE_SEL_N    (BYTE_LANE_SEL_N),
  .BURST_ORDER_SEL_N  (BURST_ORDER_SEL_N),
  .SLEEP_REQ          (SLEEP_REQ),
  .DQ_I               (DQ_I),
  .DQ_O               (DQ_O),
  .DQ_OE              (DQ_OE),
  .WRITE_READY        (WRITE_READY),
  .SLEEPING           (SLEEPING)
);

// ---- sram_ctrl_model.sv ----
// Controller model driving the port's bus, select and sleep pins.
// Assumes tasks are called from one bench process; pins change after CLK rises.
`timescale 1ns/1ps

module sram_ctrl_model (
  input  wire logic                        CLK,
  output logic [sram_port_pkg::ADDR_W-1:0] ADDR,
  output logic                             CHIP_EN_N,
  output logic                             SELECT_HI,
  output logic                             SELECT_LO_N,
  output logic                             PROC_ADDR_STROBE_N,
  output logic                             CTRL_ADDR_STROBE_N,
  output logic                             BURST_ADVANCE_N,
  output logic                             GLOBAL_WRITE_N,
  output logic                             BYTE_WRITE_EN_N,
  output logic [sram_port_pkg::LANES-1:0]  BYTE_LANE_SEL_N,
  output logic                             BURST_ORDER_SEL_N,
  output logic                             SLEEP_REQ,
  output logic [sram_port_pkg::DATA_W-1:0] DQ_I
);
  initial
  begin
    {CHIP_EN_N, SELECT_HI, SELECT_LO_N, PROC_ADDR_STROBE_N} = 4'hB;
    {CTRL_ADDR_STROBE_N, BURST_ADVANCE_N, GLOBAL_WRITE_N, BYTE_WRITE_EN_N} = 4'hF;
    {BURST_ORDER_SEL_N, SLEEP_REQ, BYTE_LANE_SEL_N} = 6'h0F;
    ADDR = 18'h0;
    DQ_I = 36'h0;
  end

  task cyc(input logic ps, cs, sel, advance_n, glob_n, byte_en_n, input logic [3:0] ln,
           input logic [17:0] a, input logic [35:0] d);
    @(posedge CLK);
    PROC_ADDR_STROBE_N <= ps;
    CTRL_ADDR_STROBE_N <= cs;
    CHIP_EN_N          <= !sel;
    SELECT_HI          <= sel;
    SELECT_LO_N        <= !sel;
    BURST_ADVANCE_N    <= advance_n;
    GLOBAL_WRITE_N     <= glob_n;
    BYTE_WRITE_EN_N    <= byte_en_n;
    BYTE_LANE_SEL_N    <= ln;
    ADDR               <= sel ? a : ~ADDR;
    DQ_I               <= (glob_n && byte_en_n) ? ~DQ_I : d;
  endtask : cyc

  task idle;
    cyc(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, 18'h0, 36'h0);
  endtask : idle

  task order(input logic v);
    idle();
    BURST_ORDER_SEL_N <= v;
    repeat (sram_port_pkg::CFG_SETUP_CYC_I + 1) idle();
  endtask : order

  task sleep_pin(input logic v);
    @(posedge CLK);
    SLEEP_REQ <= v;
  endtask : sleep_pin
endmodule : sram_ctrl_model

// ---- pipelined_burst_sram_port_tb.sv ----
// Self-checking bench for the pipelined burst SRAM port.
// Assumes the controller model drives every bus input of the port.
`timescale 1ns/1ps

module pipelined_burst_sram_port_tb;
  logic                             CLK, RESET, DQ_OE, WRITE_READY, SLEEPING;
  logic [sram_port_pkg::ADDR_W-1:0] ADDR;
  logic CHIP_EN_N, SELECT_HI, SELECT_LO_N, PROC_ADDR_STROBE_N, CTRL_ADDR_STROBE_N;
  logic BURST_ADVANCE_N, GLOBAL_WRITE_N, BYTE_WRITE_EN_N, BURST_ORDER_SEL_N, SLEEP_REQ;
  logic [sram_port_pkg::LANES-1:0]  BYTE_LANE_SEL_N;
  logic [sram_port_pkg::DATA_W-1:0] DQ_I, DQ_O;
  logic [35:0]                      mem [16];
  int                               num_errors, checks;

  sram_burst_port i_dut (
    .CLK                (CLK),
    .RESET              (RESET),
    .ADDR               (ADDR),
    .CHIP_EN_N          (CHIP_EN_N),
    .SELECT_HI          (SELECT_HI),
    .SELECT_LO_N        (SELECT_LO_N),
    .PROC_ADDR_STROBE_N (PROC_ADDR_STROBE_N),
    .CTRL_ADDR_STROBE_N (CTRL_ADDR_STROBE_N),
    .BURST_ADVANCE_N    (BURST_ADVANCE_N),
    .GLOBAL_WRITE_N     (GLOBAL_WRITE_N),
    .BYTE_WRITE_EN_N    (BYTE_WRITE_EN_N),
    .BYTE_LANE_SEL_N    (BYTE_LANE_SEL_N),
    .BURST_ORDER_SEL_N  (BURST_ORDER_SEL_N),
    .SLEEP_REQ          (SLEEP_REQ),
    .DQ_I               (DQ_I),
    .DQ_O               (DQ_O),
    .DQ_OE              (DQ_OE),
    .WRITE_READY        (WRITE_READY),
    .SLEEPING           (SLEEPING)
  );
  sram_ctrl_model i_ctrl (
    .CLK                (CLK),
    .ADDR               (ADDR),
    .CHIP_EN_N          (CHIP_EN_N),
    .SELECT_HI          (SELECT_HI),
    .SELECT_LO_N        (SELECT_LO_N),
    .PROC_ADDR_STROBE_N (PROC_ADDR_STROBE_N),
    .CTRL_ADDR_STROBE_N (CTRL_ADDR_STROBE_N),
    .BURST_ADVANCE_N    (BURST_ADVANCE_N),
    .GLOBAL_WRITE_N     (GLOBAL_WRITE_N),
    .BYTE_WRITE_EN_N    (BYTE_WRITE_EN_N),
    .BYTE_LANE_SEL_N    (BYTE_LANE_SEL_N),
    .BURST_ORDER_SEL_N  (BURST_ORDER_SEL_N),
    .SLEEP_REQ          (SLEEP_REQ),
    .DQ_I               (DQ_I)
  );

  initial CLK = 1'b0;
  always #25 CLK = ~CLK;

  task chk(input logic [35:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task finish_test;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test

  function automatic logic [35:0] pat(input logic [3:0] a);
    pat = {5'h11, a, 5'h12, a, 5'h13, a, 5'h14, a};
  endfunction : pat

  task wr(input logic cont, advance_n, glob_n, input logic [3:0] a, ln,
          input logic [35:0] d);
    i_ctrl.cyc(1'b1, cont, 1'b1, advance_n, glob_n, !glob_n, ln, {14'h0, a}, d);
    for (int k = 0; k < 4; k++)
      if (!glob_n || !ln[k]) mem[a][9*k +: 9] = d[9*k +: 9];
  endtask : wr

  task rd(input logic proc, input logic [3:0] b, input logic [4:0] hold);
    logic [1:0] c;
    logic [3:0] a;
    c = 2'h0;
    for (int i = 0; i < 6; i++)
    begin
      if (i == 0)
        i_ctrl.cyc(!proc, proc, 1'b1, 1'b1, !proc, 1'b1, 4'hF, {14'h0, b}, 36'h0);
      else if (i < 5)
        i_ctrl.cyc(1'b1, 1'b1, 1'b1, hold[i], 1'b1, 1'b1, 4'hF, 18'h0, 36'h0);
      else
        i_ctrl.idle();
      if (i > 0)
      begin
        a = {b[3:2], BURST_ORDER_SEL_N ? b[1:0] ^ c : b[1:0] + c};
        #1 chk(DQ_O, mem[a]);
        chk({35'h0, DQ_OE}, 36'h1);
        if (i < 5) c = c + {1'b0, !hold[i]};
      end
    end
  endtask : rd

  task t_write;
    for (int a = 0; a < 16; a++)
      wr(1'b0, 1'b0, 1'b0, 4'(a), 4'h0, pat(4'(a)));
    wr(1'b0, 1'b0, 1'b1, 4'h4, 4'h0, 36'h9_55AA_33CC);
    wr(1'b0, 1'b0, 1'b1, 4'h6, 4'hA, 36'hF_0F0F_0F0F);
    wr(1'b0, 1'b0, 1'b0, 4'h8, 4'h0, ~pat(4'h8));
    wr(1'b1, 1'b0, 1'b0, 4'h9, 4'h0, ~pat(4'h9));
    wr(1'b1, 1'b1, 1'b0, 4'h9, 4'h0, ~pat(4'h9));
    wr(1'b1, 1'b0, 1'b0, 4'hA, 4'h0, ~pat(4'hA));
    repeat (12) i_ctrl.idle();
    #1 chk({35'h0, WRITE_READY}, 36'h1);
  endtask : t_write

  task t_reads;
    i_ctrl.order(1'b0);
    rd(1'b1, 4'h1, 5'h00);
    rd(1'b0, 4'h6, 5'h04);
    i_ctrl.order(1'b1);
    rd(1'b0, 4'h9, 5'h00);
    rd(1'b1, 4'h4, 5'h08);
  endtask : t_reads

  task t_sleep;
    int n;
    i_ctrl.sleep_pin(1'b1);
    repeat (3) i_ctrl.idle();
    #1 chk({34'h0, SLEEPING, DQ_OE}, 36'h2);
    i_ctrl.sleep_pin(1'b0);
    n = 0;
    while (SLEEPING !== 1'b0 && n < 8)
    begin
      i_ctrl.idle();
      #1 n++;
    end
    if (n == 8)
    begin
      num_errors++;
      finish_test;
    end
    rd(1'b0, 4'hE, 5'h00);
  endtask : t_sleep

  initial
  begin
    RESET = 1'b1;
    num_errors = 0;
    checks = 0;
    repeat (8) @(posedge CLK);
    RESET <= 1'b0;
    t_write;
    t_reads;
    t_sleep;
    finish_test;
  end
endmodule : pipelined_burst_sram_port_tb
